// ==== src/ogdc_top.v ====
// Output guard and datapath configuration word with its control effects
`timescale 1ns/10ps
`include "ogdc_map.vh"
module ogdc_top #(
    parameter SAMPLE_W = 16
) (
    input  wire                    clk_i,
    input  wire                    resetn_i,
    input  wire                    wr_stb_i,
    input  wire                    rd_stb_i,
    input  wire [`OGDC_ADDR_W-1:0] addr_i,
    input  wire [`OGDC_DATA_W-1:0] wdata_i,
    output reg  [`OGDC_DATA_W-1:0] rdata_o,
    output reg                     rvalid_o,
    input  wire                    dacclk_gone_i,
    input  wire                    datclk_gone_i,
    input  wire                    fifo_collision_i,
    input  wire                    mask_dacclk_i,
    input  wire                    mask_datclk_i,
    input  wire                    mask_coll_i,
    input  wire                    mask_out_off_i,
    input  wire                    alarm_clear_i,
    input  wire [SAMPLE_W-1:0]     sample_i,
    output reg                     outputs_off_o,
    output reg                     four_wire_port_sel_o,
    output reg                     nco_run_o,
    output reg  [SAMPLE_W-1:0]     nco_phase_o,
    output wire [SAMPLE_W-1:0]     sample_o
);
    localparam N_SYNC = 2;
    localparam N_SRC  = 3;

    reg  [`OGDC_DATA_W-1:0] output_guard_datapath_cfg_q;
    reg  [`OGDC_DATA_W-1:0] output_guard_datapath_cfg_d;
    reg  [`OGDC_DATA_W-1:0] rdata_d;
    reg  [N_SRC-1:0]        alarm_lat_q;
    reg                     off_d;
    reg  [SAMPLE_W-1:0]     nco_phase_d;
    wire                    cfg_hit;
    wire [N_SYNC-1:0]       gone_raw;
    wire [N_SYNC-1:0]       gone_lvl;
    wire [N_SRC-1:0]        alarm_evt;
    wire [N_SRC-1:0]        shut_en;
    wire [N_SRC-1:0]        src_mask;
    wire [N_SRC-1:0]        alarm_lat_d;
    wire [N_SRC-1:0]        trip_d;
    wire                    rev_bus_en;
    wire                    twos_sel;
    wire                    mix_en;
    wire                    mix_gain_en;
    wire                    nco_en;
    genvar                  s;

    assign cfg_hit   = (addr_i == `OGDC_CFG_ADDR);
    // Source order is converter clock, data clock, collision, high to low
    assign gone_raw  = {dacclk_gone_i, datclk_gone_i};
    assign alarm_evt = {gone_lvl, fifo_collision_i};
    assign src_mask  = {mask_dacclk_i, mask_datclk_i, mask_coll_i};
    assign shut_en   = {output_guard_datapath_cfg_q[`OGDC_BIT_DACCLK_OFF],
                        output_guard_datapath_cfg_q[`OGDC_BIT_DATCLK_OFF],
                        output_guard_datapath_cfg_q[`OGDC_BIT_COLL_OFF]};
    // Datapath controls straight from the word, no extra delay
    assign rev_bus_en  = output_guard_datapath_cfg_q[`OGDC_BIT_REV_BUS];
    assign twos_sel    = output_guard_datapath_cfg_q[`OGDC_BIT_TWOS];
    assign mix_en      = output_guard_datapath_cfg_q[`OGDC_BIT_MIX_EN];
    assign mix_gain_en = output_guard_datapath_cfg_q[`OGDC_BIT_MIX_GAIN];
    assign nco_en      = output_guard_datapath_cfg_q[`OGDC_BIT_NCO_EN];

    // Whole word loads in one edge so no field ever mixes old and new
    always @* begin
        output_guard_datapath_cfg_d = output_guard_datapath_cfg_q;
        if (wr_stb_i && cfg_hit) begin
            output_guard_datapath_cfg_d = wdata_i & ~`OGDC_CFG_RSVD_MASK;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            output_guard_datapath_cfg_q <= `OGDC_CFG_RESET;
        end else begin
            output_guard_datapath_cfg_q <= output_guard_datapath_cfg_d;
        end
    end

    // Reads of any other word return zero, never stale data
    always @* begin
        rdata_d = {`OGDC_DATA_W{1'b0}};
        if (rd_stb_i && cfg_hit) begin
            rdata_d = output_guard_datapath_cfg_q;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= {`OGDC_DATA_W{1'b0}};
        end else begin
            rdata_o <= rdata_d;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_stb_i;
        end
    end

    // Clock-loss flags come from the monitor's own domain
    generate
        for (s = 0; s < N_SYNC; s = s + 1) begin : g_sync
            reg [2:0] sync_q;
            reg       lvl_q;
            always @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    sync_q <= 3'h0;
                    lvl_q  <= 1'b0;
                end else begin
                    sync_q <= {sync_q[1:0], gone_raw[s]};
                    // Stages two and three must agree so a metastable glitch never counts
                    if (sync_q[2] == sync_q[1]) begin
                        lvl_q <= sync_q[2];
                    end
                end
            end
            assign gone_lvl[s] = lvl_q;
        end
    endgenerate

    // A new event in the clearing cycle keeps the alarm set
    generate
        for (s = 0; s < N_SRC; s = s + 1) begin : g_alarm
            assign alarm_lat_d[s] = alarm_evt[s] | (alarm_lat_q[s] & ~alarm_clear_i);
            assign trip_d[s]      = shut_en[s] & ~src_mask[s] & alarm_lat_q[s];
        end
    endgenerate

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alarm_lat_q <= {N_SRC{1'b0}};
        end else begin
            alarm_lat_q <= alarm_lat_d;
        end
    end

    // Output-off mask overrides every source at once
    always @* begin
        off_d = 1'b0;
        if (!mask_out_off_i) begin
            off_d = |trip_d;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            outputs_off_o <= 1'b0;
        end else begin
            outputs_off_o <= off_d;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            four_wire_port_sel_o <= 1'b0;
        end else begin
            four_wire_port_sel_o <= output_guard_datapath_cfg_q[`OGDC_BIT_FOUR_WIRE];
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nco_run_o <= 1'b0;
        end else begin
            nco_run_o <= nco_en;
        end
    end

    // Phase freezes when the oscillator is off to save power
    always @* begin
        nco_phase_d = nco_phase_o;
        if (nco_en) begin
            nco_phase_d = nco_phase_o + {{(SAMPLE_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nco_phase_o <= {SAMPLE_W{1'b0}};
        end else begin
            nco_phase_o <= nco_phase_d;
        end
    end

    ogdc_sample_path #(
        .W(SAMPLE_W)
    ) u_path (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .sample_i   (sample_i),
        .nco_i      (nco_phase_o),
        .rev_bus_i  (rev_bus_en),
        .twos_i     (twos_sel),
        .mix_en_i   (mix_en),
        .mix_gain_i (mix_gain_en),
        .nco_en_i   (nco_en),
        .sample_o   (sample_o)
    );
endmodule // ogdc_top

// ==== src/ogdc_map.vh ====
// Offsets, field positions, reset value and widths of the output guard config word
`ifndef OGDC_MAP_VH
`define OGDC_MAP_VH
`define OGDC_CFG_ADDR        7'h02
`define OGDC_CFG_RESET       16'h7000
`define OGDC_CFG_RSVD_MASK   16'h8f05
`define OGDC_BIT_DACCLK_OFF  14
`define OGDC_BIT_DATCLK_OFF  13
`define OGDC_BIT_COLL_OFF    12
`define OGDC_BIT_FOUR_WIRE   7
`define OGDC_BIT_MIX_EN      6
`define OGDC_BIT_MIX_GAIN    5
`define OGDC_BIT_NCO_EN      4
`define OGDC_BIT_REV_BUS     3
`define OGDC_BIT_TWOS        1
`define OGDC_DATA_W          16
`define OGDC_ADDR_W          7
`endif

// ==== src/ogdc_sample_path.v ====
// Sample path: bus reversal, format conversion, mixer with optional 6dB gain
`timescale 1ns/10ps
module ogdc_sample_path #(
    parameter W = 16
) (
    input  wire         clk_i,
    input  wire         resetn_i,
    input  wire [W-1:0] sample_i,
    input  wire [W-1:0] nco_i,
    input  wire         rev_bus_i,
    input  wire         twos_i,
    input  wire         mix_en_i,
    input  wire         mix_gain_i,
    input  wire         nco_en_i,
    output reg  [W-1:0] sample_o
);
    wire [W-1:0] rev_w;
    wire [W-1:0] signed_w;
    wire [W-1:0] mixed_w;
    wire [W-1:0] gained_w;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_rev
            assign rev_w[g] = rev_bus_i ? sample_i[W-1-g] : sample_i[g];
        end
    endgenerate
    // Offset binary flips the sign bit to reach two's complement
    assign signed_w = twos_i ? rev_w : {~rev_w[W-1], rev_w[W-2:0]};
    // Coarse mixing without the oscillator inverts every bit of the sample
    assign mixed_w  = nco_en_i ? (signed_w ^ nco_i) : ~signed_w;
    assign gained_w = mix_gain_i ? {mixed_w[W-2:0], 1'b0} : mixed_w;
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sample_o <= {W{1'b0}};
        end else begin
            sample_o <= mix_en_i ? gained_w : signed_w;
        end
    end
endmodule // ogdc_sample_path

// ==== verif/ogdc_monitor.sv ====
// Assertion checker for the output guard config word
`timescale 1ns/10ps
module ogdc_monitor (
    input wire        clk_i, resetn_i, wr_stb_i, rd_stb_i, rvalid_o, outputs_off_o, four_wire_port_sel_o,
    input wire        nco_run_o, dacclk_gone_i, fifo_collision_i, mask_dacclk_i, mask_coll_i, mask_out_off_i,
    input wire [6:0]  addr_i,
    input wire [15:0] wdata_i, rdata_o, nco_phase_o
);
    reg  [15:0] sh_q;
    wire        wr_hit = wr_stb_i && addr_i == 7'h02;
    wire        rd_hit = rd_stb_i && addr_i == 7'h02;
    // Shadow of the word, so checks need no view inside
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) sh_q <= 16'h7000;
        else if (wr_hit) sh_q <= wdata_i & 16'h70fa;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_coll; sh_q[12] && fifo_collision_i && !mask_coll_i && !mask_out_off_i; endsequence
    sequence s_dac; sh_q[14] && dacclk_gone_i && !mask_dacclk_i && !mask_out_off_i; endsequence
    a_read_returns_word: assert property (rd_hit |=> rvalid_o && rdata_o == $past(sh_q)) else $error("Bad read");
    a_no_stray_valid: assert property (!rd_stb_i |=> !rvalid_o) else $error("Stray valid");
    a_reserved_read_zero: assert property (rvalid_o |-> (rdata_o & 16'h8f05) == 16'h0000) else $error("Rsvd set");
    a_four_wire_follows: assert property (four_wire_port_sel_o == $past(sh_q[7])) else $error("Port sel");
    a_nco_run_follows: assert property (nco_run_o == $past(sh_q[4])) else $error("Nco run");
    a_nco_idle_stable: assert property (!sh_q[4] |=> $stable(nco_phase_o)) else $error("Nco moved");
    a_coll_shuts_off: assert property (s_coll |-> ##[1:2] outputs_off_o) else $error("No coll off");
    a_dac_shuts_off: assert property (s_dac [*8] |-> outputs_off_o) else $error("No clk off");
endmodule // ogdc_monitor
bind ogdc_top ogdc_monitor u_mon (.clk_i(clk_i), .resetn_i(resetn_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
    .rvalid_o(rvalid_o), .outputs_off_o(outputs_off_o), .four_wire_port_sel_o(four_wire_port_sel_o),
    .nco_run_o(nco_run_o), .dacclk_gone_i(dacclk_gone_i), .fifo_collision_i(fifo_collision_i),
    .mask_dacclk_i(mask_dacclk_i), .mask_coll_i(mask_coll_i), .mask_out_off_i(mask_out_off_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .nco_phase_o(nco_phase_o));

// ==== verif/output_guard_and_datapath_config_tb.sv ====
// Self-checking bench for the output guard config word
`timescale 1ns/10ps
module output_guard_and_datapath_config_tb;
    reg         clk_i = 1'b0, resetn_i = 1'b0, wr_stb_i = 1'b0, rd_stb_i = 1'b0, alarm_clear_i = 1'b0;
    reg         mask_out_off_i = 1'b0;
    reg  [2:0]  src = 3'h0, msk = 3'h0;
    reg  [6:0]  addr_i = 7'h00;
    reg  [15:0] wdata_i = 16'h0000, sample_i = 16'h0000;
    reg  [31:0] rnd;
    wire [15:0] rdata_o, nco_phase_o, sample_o;
    wire        rvalid_o, outputs_off_o, four_wire_port_sel_o, nco_run_o;
    integer     err_total = 0, num_checks = 0, seed = 79, m_cfg = 16'h7000, k, p, i;
    reg  [15:0] m_phase = 16'h0000, m_nco_in = 16'h0000;
    always #50 clk_i = ~clk_i;
    // Model of the oscillator phase and of the phase the path last used
    always @(posedge clk_i) begin
        m_nco_in <= m_phase;
        if (resetn_i && m_cfg[4]) m_phase <= m_phase + 16'h0001;
    end
    ogdc_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .dacclk_gone_i(src[2]), .datclk_gone_i(src[1]),
        .fifo_collision_i(src[0]), .mask_dacclk_i(msk[2]), .mask_datclk_i(msk[1]), .mask_coll_i(msk[0]),
        .mask_out_off_i(mask_out_off_i), .alarm_clear_i(alarm_clear_i), .sample_i(sample_i),
        .outputs_off_o(outputs_off_o), .four_wire_port_sel_o(four_wire_port_sel_o), .nco_run_o(nco_run_o),
        .nco_phase_o(nco_phase_o), .sample_o(sample_o));
    task check(input [15:0] seen, input [15:0] exp); begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    end endtask
    // Sample path model: reversal, format, mixer, gain
    function [15:0] f_path(input [15:0] s, input [15:0] c, input [15:0] ph);
        reg [15:0] r;
        integer    b;
        begin
            for (b = 0; b < 16; b = b + 1) r[b] = c[3] ? s[15-b] : s[b];
            if (!c[1]) r[15] = ~r[15];
            if (c[6]) begin
                r = c[4] ? (r ^ ph) : ~r;
                if (c[5]) r = {r[14:0], 1'b0};
            end
            f_path = r;
        end
    endfunction
    task wr(input [6:0] a, input [15:0] d); begin
        @(negedge clk_i);
        addr_i = a;
        wdata_i = d;
        wr_stb_i = 1'b1;
        @(negedge clk_i);
        wr_stb_i = 1'b0;
        if (a == 7'h02) m_cfg = d & 16'h70fa;
    end endtask
    task rd(input [6:0] a, input [15:0] exp); begin
        @(negedge clk_i);
        addr_i = a;
        rd_stb_i = 1'b1;
        @(negedge clk_i);
        rd_stb_i = 1'b0;
        check({15'h0000, rvalid_o}, 16'h0001);
        check(rdata_o, exp);
    end endtask
    task stop_test; begin
        $display("Checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    end endtask
    initial begin
        #2000000;
        err_total = err_total + 1;
        stop_test;
    end
    initial begin
        repeat (4) @(negedge clk_i);
        resetn_i = 1'b1;
        rd(7'h02, 16'h7000);
        for (i = 0; i < 8; i = i + 1) begin
            rnd = (i == 0) ? 32'hffffffff : $random(seed);
            sample_i = rnd[31:16];
            wr(7'h02, rnd[15:0]);
            rd(7'h02, m_cfg[15:0]);
            check({15'h0000, four_wire_port_sel_o}, {15'h0000, m_cfg[7]});
            check({15'h0000, nco_run_o}, {15'h0000, m_cfg[4]});
            check(nco_phase_o, m_phase);
            check(sample_o, f_path(sample_i, m_cfg[15:0], m_nco_in));
        end
        wr(7'h05, 16'hffff);
        rd(7'h02, m_cfg[15:0]);
        rd(7'h05, 16'h0000);
        $display("Config access test done");
        // Per source: armed, own mask, output mask, disabled
        for (k = 0; k < 3; k = k + 1) begin
            for (p = 0; p < 4; p = p + 1) begin
                wr(7'h02, (p == 3) ? 16'h0000 : 16'h4000 >> k);
                msk = (p == 1) ? 3'b100 >> k : 3'b000;
                mask_out_off_i = (p == 2);
                src = 3'b100 >> k;
                repeat (12) @(negedge clk_i);
                check({15'h0000, outputs_off_o}, {15'h0000, p == 0});
                src = 3'b000;
                // Clear only after the synchronised source is gone, else it re-latches
                repeat (6) @(negedge clk_i);
                alarm_clear_i = 1'b1;
                @(negedge clk_i);
                alarm_clear_i = 1'b0;
                repeat (4) @(negedge clk_i);
                check({15'h0000, outputs_off_o}, 16'h0000);
            end
        end
        $display("Shutoff test done");
        stop_test;
    end
endmodule // output_guard_and_datapath_config_tb
